/* verilog/psfp_defines.svh */
`ifndef PSFP_DEFINES_SVH
`define PSFP_DEFINES_SVH

// timing figures in ns, and the clock period they are counted against
`define PSFP_CLK_PERIOD_NS      50
`define PSFP_OC_DELAY_NS        100
`define PSFP_OC_DELAY_CYC       ((`PSFP_OC_DELAY_NS + `PSFP_CLK_PERIOD_NS - 1) / `PSFP_CLK_PERIOD_NS)
`define PSFP_WINDOW_NS          100
`define PSFP_WINDOW_CYC         ((`PSFP_WINDOW_NS + `PSFP_CLK_PERIOD_NS - 1) / `PSFP_CLK_PERIOD_NS)
`define PSFP_SC_RESET_NS        400
`define PSFP_SC_RESET_CYC       ((`PSFP_SC_RESET_NS + `PSFP_CLK_PERIOD_NS - 1) / `PSFP_CLK_PERIOD_NS)
`define PSFP_CNT_W              8

// status output levels (fault_n, current_trouble_n)
`define PSFP_STAT_IDLE          1'b1
`define PSFP_STAT_ACTIVE        1'b0

`endif

/* verilog/psfp_pkg.sv */
package psfp_pkg;
    typedef enum logic [2:0] {
        PSFP_ST_STARTUP,
        PSFP_ST_RUN,
        PSFP_ST_OVERCURRENT,
        PSFP_ST_SHORT,
        PSFP_ST_DIODE,
        PSFP_ST_DRV_HOT
    } psfp_state_e;

    typedef logic [7:0] psfp_cnt_t;
endpackage : psfp_pkg

/* verilog/psfp_guard.sv */
`timescale 1ns/1ns
`include "psfp_defines.svh"

// Notes on behaviour
// - overcurrent after delay: switch off, flag low
// - overcurrent clears when command goes low
// - delayed overcurrent versus short detect classifies
// - short turnoff uses slowed drive
// - short latched until long low or power
// - switch overheated: diode emulation mode
// - driver overheated: all off, no emulation
// - fault low while hot, auto release
// - driver cools first: back to emulation
// - undervoltage: switch off, fault low
// - aux regulator follows undervoltage hysteresis
// - status encoding of the two outputs
// - both outputs push-pull, high when normal
// - fault low until series switch on
// - slew pin open holds fault low
// - grounded current output merges reporting
// - protection independent of output observation
module psfp_guard
    import psfp_pkg::*;
(
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic clk_en,
    input  wire logic gate_cmd,
    input  wire logic overcurrent_det,
    input  wire logic short_det,
    input  wire logic switch_hot,
    input  wire logic driver_hot,
    input  wire logic supply_ok,
    input  wire logic supply_above_6v,
    input  wire logic series_switch_on,
    input  wire logic slew_set_pin_open,
    input  wire logic current_trouble_pin_in,
    input  wire logic third_quadrant,
    output logic      switch_on,
    output logic      slow_turnoff,
    output logic      diode_emulation,
    output logic      aux_5v_enable,
    output logic      fault_n,
    output logic      current_trouble_n
);

    // every pin but clk, sys_rst and clk_en passes two flip-flops; stage one feeds stage two only
    localparam int NSYNC = 10;
    logic [NSYNC-1:0] sync1_ff;
    logic [NSYNC-1:0] sync2_ff;
    wire  [NSYNC-1:0] raw_in = {gate_cmd, overcurrent_det, short_det, switch_hot, driver_hot,
                                supply_ok, series_switch_on, slew_set_pin_open,
                                current_trouble_pin_in, third_quadrant};

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
        end else if (clk_en) begin
            sync1_ff <= raw_in;
            sync2_ff <= sync1_ff;
        end
    end

    wire s_cmd   = sync2_ff[9];
    wire s_oc    = sync2_ff[8];
    wire s_sc    = sync2_ff[7];
    wire s_shot  = sync2_ff[6];
    wire s_dhot  = sync2_ff[5];
    wire s_uvok  = sync2_ff[4];
    wire s_ser   = sync2_ff[3];
    wire s_open  = sync2_ff[2];
    wire s_ocpin = sync2_ff[1];
    wire s_q3    = sync2_ff[0];

    logic aux_sync1_ff;
    logic aux_sync2_ff;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            aux_sync1_ff <= 1'b0;
            aux_sync2_ff <= 1'b0;
        end else if (clk_en) begin
            aux_sync1_ff <= supply_above_6v;
            aux_sync2_ff <= aux_sync1_ff;
        end
    end

    // strap sampled once after reset release, held until the next sys_rst
    // strap capture once
    logic strap_done_ff;
    logic combined_ff;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            strap_done_ff <= 1'b0;
            combined_ff   <= 1'b0;
        end else if (clk_en && !strap_done_ff && s_uvok) begin
            strap_done_ff <= 1'b1;
            combined_ff   <= ~s_ocpin;
        end
    end

    // overcurrent must persist for the turn-off delay
    psfp_cnt_t oc_cnt_ff;
    psfp_cnt_t win_cnt_ff;
    psfp_cnt_t low_cnt_ff;
    wire oc_tripped  = (oc_cnt_ff >= psfp_cnt_t'(`PSFP_OC_DELAY_CYC));
    wire win_elapsed = (win_cnt_ff >= psfp_cnt_t'(`PSFP_WINDOW_CYC));
    wire low_elapsed = (low_cnt_ff >= psfp_cnt_t'(`PSFP_SC_RESET_CYC));

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            oc_cnt_ff  <= '0;
            win_cnt_ff <= '0;
            low_cnt_ff <= '0;
        end else if (clk_en) begin
            oc_cnt_ff  <= (s_oc && !oc_tripped) ? oc_cnt_ff + 8'h01 : (s_oc ? oc_cnt_ff : 8'h00);
            win_cnt_ff <= (s_oc && !win_elapsed) ? win_cnt_ff + 8'h01 : (s_oc ? win_cnt_ff : 8'h00);
            low_cnt_ff <= (!s_cmd && !low_elapsed) ? low_cnt_ff + 8'h01 : (s_cmd ? 8'h00 : low_cnt_ff);
        end
    end

    wire short_first = s_sc && !win_elapsed;
    wire oc_event    = oc_tripped && !short_first;

    psfp_state_e state_ff;
    psfp_state_e nxt_state;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            PSFP_ST_STARTUP: begin
                if (s_ser && s_uvok)
                    nxt_state = PSFP_ST_RUN;
            end
            PSFP_ST_RUN: begin
                if (short_first)
                    nxt_state = PSFP_ST_SHORT;
                else if (oc_event && s_cmd)
                    nxt_state = PSFP_ST_OVERCURRENT;
            end
            PSFP_ST_OVERCURRENT: begin
                if (short_first)
                    nxt_state = PSFP_ST_SHORT;
                else if (!s_cmd)
                    nxt_state = PSFP_ST_RUN;
            end
            PSFP_ST_SHORT: begin
                if (low_elapsed)
                    nxt_state = PSFP_ST_RUN;
            end
            PSFP_ST_DIODE: begin
                if (!s_shot)
                    nxt_state = PSFP_ST_RUN;
            end
            PSFP_ST_DRV_HOT: begin
                if (!s_dhot)
                    nxt_state = s_shot ? PSFP_ST_DIODE : PSFP_ST_RUN;
            end
            default: nxt_state = PSFP_ST_STARTUP;
        endcase
        // thermal states outrank current states; undervoltage outranks all
        // driver overheat
        if (state_ff != PSFP_ST_STARTUP && s_dhot)
            nxt_state = PSFP_ST_DRV_HOT;
        else if (state_ff != PSFP_ST_STARTUP && state_ff != PSFP_ST_DRV_HOT && s_shot)
            nxt_state = PSFP_ST_DIODE;
        if (!s_uvok)
            nxt_state = PSFP_ST_STARTUP;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst)
            state_ff <= PSFP_ST_STARTUP;
        else if (clk_en)
            state_ff <= nxt_state;
    end

    logic aux_ff;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst)
            aux_ff <= 1'b0;
        else if (clk_en) begin
            if (s_uvok && !s_dhot)
                aux_ff <= 1'b1;
            else if (!aux_sync2_ff || s_dhot)
                aux_ff <= 1'b0;
        end
    end

    // fault classes from state and pins
    wire is_oc      = (state_ff == PSFP_ST_OVERCURRENT);
    wire is_sc      = (state_ff == PSFP_ST_SHORT);
    wire is_hot     = (state_ff == PSFP_ST_DIODE) || (state_ff == PSFP_ST_DRV_HOT);
    wire fault_lvl  = (state_ff == PSFP_ST_STARTUP) || is_hot || s_open;
    wire nxt_fault_n = !(fault_lvl || is_sc || (combined_ff && is_oc));
    wire nxt_cur_n   = !(is_oc || is_sc) || combined_ff;
    wire nxt_switch  = (state_ff == PSFP_ST_RUN) ? (s_cmd && !oc_event && !short_first) :
                       (state_ff == PSFP_ST_DIODE) ? s_q3 : 1'b0;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            switch_on         <= 1'b0;
            slow_turnoff      <= 1'b0;
            diode_emulation   <= 1'b0;
            fault_n           <= `PSFP_STAT_ACTIVE;
            current_trouble_n <= `PSFP_STAT_IDLE;
        end else if (clk_en) begin
            switch_on         <= nxt_switch;
            slow_turnoff      <= is_sc || (nxt_state == PSFP_ST_SHORT);
            diode_emulation   <= (state_ff == PSFP_ST_DIODE);
            fault_n           <= nxt_fault_n;
            current_trouble_n <= nxt_cur_n;
        end
    end

    assign aux_5v_enable = aux_ff;

endmodule : psfp_guard

/* tb/psfp_ctrl_model.sv */
`timescale 1ns/1ns
module psfp_ctrl_model (
    input  wire logic clk,
    input  wire logic cmd_req,
    input  wire logic recover,
    input  wire logic fault_n,
    input  wire logic current_trouble_n,
    output logic      gate_cmd = 1'b0
);
    logic [3:0] hold_ff = 4'h0;
    always @(posedge clk) begin
        if (recover && !fault_n && !current_trouble_n && hold_ff == 4'h0)
            hold_ff <= 4'ha;
        else if (hold_ff != 4'h0)
            hold_ff <= hold_ff - 4'h1;
        gate_cmd <= cmd_req && hold_ff == 4'h0;
    end
endmodule : psfp_ctrl_model

/* tb/psfp_guard_props.sv */
`timescale 1ns/1ns
module psfp_guard_props (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic gate_cmd,
    input wire logic overcurrent_det,
    input wire logic driver_hot,
    input wire logic supply_ok,
    input wire logic slew_set_pin_open,
    input wire logic switch_on,
    input wire logic slow_turnoff,
    input wire logic diode_emulation,
    input wire logic aux_5v_enable,
    input wire logic fault_n,
    input wire logic current_trouble_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_oc_off: assert property ((overcurrent_det && gate_cmd)[*8] |-> !switch_on)
        else $error("switch on under overcurrent");
    a_oc_clear: assert property ((!current_trouble_n && fault_n) ##1 (!gate_cmd)[*6] |-> current_trouble_n)
        else $error("overcurrent flag stuck");
    a_slow_off: assert property (slow_turnoff |-> !switch_on)
        else $error("slow turnoff with switch on");
    a_short_latch: assert property (!fault_n && !current_trouble_n && gate_cmd |=> !switch_on)
        else $error("short not latched");
    a_drv_hot_off: assert property (driver_hot[*6] |-> !aux_5v_enable && !switch_on && !diode_emulation)
        else $error("driver hot not shut");
    a_diode_fault: assert property (diode_emulation && $past(diode_emulation) |-> !fault_n)
        else $error("fault high in emulation");
    a_uv_hold: assert property ((!supply_ok)[*6] |-> !switch_on && !fault_n)
        else $error("undervoltage not held");
    a_slew_open: assert property (slew_set_pin_open[*6] |-> !fault_n)
        else $error("open pin not flagged");
    c_short: cover property (!fault_n && !current_trouble_n);
    c_oc: cover property (fault_n && !current_trouble_n);
    c_diode: cover property (diode_emulation);
endmodule : psfp_guard_props
bind psfp_guard psfp_guard_props props_u (.*);

/* tb/power_switch_fault_protection_tb.sv */
`timescale 1ns/1ns
module power_switch_fault_protection_tb;
    logic clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, overcurrent_det = 1'b0, short_det = 1'b0;
    logic switch_hot = 1'b0, driver_hot = 1'b0, supply_ok = 1'b1, supply_above_6v = 1'b1;
    logic series_switch_on = 1'b0, slew_set_pin_open = 1'b0, third_quadrant = 1'b0;
    logic current_trouble_pin_in = 1'b1, cmd_req = 1'b0, recover = 1'b0, gate_cmd;
    logic switch_on, slow_turnoff, diode_emulation, aux_5v_enable, fault_n, current_trouble_n;
    int miscompares = 0, checked = 0;
    psfp_guard dut_u (.*);
    psfp_ctrl_model ctrl_u (.clk, .cmd_req, .recover, .fault_n, .current_trouble_n, .gate_cmd);
    initial begin
        forever #25 clk = ~clk;
    end
    task automatic finish_test;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : finish_test
    task automatic check(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    // kind: 0 normal, 1 supply/heat/open pin, 2 overcurrent, 3 short
    function automatic logic [1:0] stat(input int kind, input bit merged);
        if (merged && kind != 0)
            return 2'b01;
        return (kind == 0) ? 2'b11 : (kind == 1) ? 2'b01 : (kind == 2) ? 2'b10 : 2'b00;
    endfunction : stat
    task automatic stat_is(input int kind, input bit merged);
        logic [1:0] e;
        e = stat(kind, merged);
        check(fault_n, e[1]);
        check(current_trouble_n, e[0]);
    endtask : stat_is
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle
    task automatic wait_normal;
        int n = 0;
        while (!(fault_n === 1'b1 && current_trouble_n === 1'b1) && n < 40) begin
            @(posedge clk);
            n++;
        end
        if (n == 40) begin
            miscompares++;
            finish_test;
        end
    endtask : wait_normal
    initial begin
        void'($urandom(9611));
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        settle(8);
        check(fault_n, 1'b0);
        @(posedge clk) series_switch_on <= 1'b1;
        settle(8);
        stat_is(0, 0);
        check(aux_5v_enable, 1'b1);
        $display("startup done");
        @(posedge clk) cmd_req <= 1'b1;
        settle(8);
        @(posedge clk) overcurrent_det <= 1'b1;
        settle(10);
        stat_is(2, 0);
        check(switch_on, 1'b0);
        @(posedge clk) cmd_req <= 1'b0;
        @(posedge clk) overcurrent_det <= 1'b0;
        settle(8);
        stat_is(0, 0);
        @(posedge clk) cmd_req <= 1'b1;
        settle(8);
        check(switch_on, 1'b1);
        $display("overcurrent done");
        @(posedge clk) short_det <= 1'b1;
        settle(10);
        stat_is(3, 0);
        check(slow_turnoff, 1'b1);
        @(posedge clk) cmd_req <= 1'b0;
        @(posedge clk) short_det <= 1'b0;
        settle(3);
        @(posedge clk) cmd_req <= 1'b1;
        settle(10);
        stat_is(3, 0);
        @(posedge clk) recover <= 1'b1;
        @(posedge clk) recover <= 1'b0;
        wait_normal();
        settle(8);
        check(switch_on, 1'b1);
        $display("short done");
        @(posedge clk) switch_hot <= 1'b1;
        @(posedge clk) third_quadrant <= 1'b1;
        settle(10);
        stat_is(1, 0);
        check(switch_on, 1'b1);
        @(posedge clk) driver_hot <= 1'b1;
        settle(10);
        check(aux_5v_enable, 1'b0);
        check(switch_on, 1'b0);
        @(posedge clk) driver_hot <= 1'b0;
        settle(12);
        check(diode_emulation, 1'b1);
        @(posedge clk) third_quadrant <= 1'b0;
        settle(8);
        check(switch_on, 1'b0);
        @(posedge clk) switch_hot <= 1'b0;
        wait_normal();
        $display("thermal done");
        @(posedge clk) slew_set_pin_open <= 1'b1;
        settle(8);
        stat_is(1, 0);
        @(posedge clk) slew_set_pin_open <= 1'b0;
        @(posedge clk) supply_ok <= 1'b0;
        settle(8);
        stat_is(1, 0);
        check(switch_on, 1'b0);
        @(posedge clk) supply_above_6v <= 1'b0;
        settle(8);
        check(aux_5v_enable, 1'b0);
        @(posedge clk) supply_above_6v <= 1'b1;
        @(posedge clk) supply_ok <= 1'b1;
        wait_normal();
        $display("supply done");
        repeat (40) begin
            @(posedge clk) cmd_req <= 1'($urandom_range(1, 0));
            third_quadrant <= 1'($urandom_range(1, 0));
            #1;
            stat_is(0, 0);
        end
        $display("random done");
        @(posedge clk) sys_rst <= 1'b1;
        current_trouble_pin_in <= 1'b0;
        cmd_req <= 1'b1;
        third_quadrant <= 1'b0;
        settle(12);
        @(posedge clk) sys_rst <= 1'b0;
        settle(12);
        @(posedge clk) current_trouble_pin_in <= 1'b1;
        @(posedge clk) overcurrent_det <= 1'b1;
        settle(10);
        stat_is(2, 1);
        stat_is(2, 1);
        $display("combined done");
        finish_test();
    end
endmodule : power_switch_fault_protection_tb
